// ===== hdl/cmo_pkg.sv
`default_nettype none
package cmo_pkg;
  // =====================================================================
  // widths
  localparam int unsigned DATA_AW   = 12;
  localparam int unsigned BUS_AW    = 8;
  localparam int unsigned PTR_COUNT = 3;

  // =====================================================================
  // register byte offsets
  localparam logic [BUS_AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [BUS_AW-1:0] REG_INSN1 = 8'h04;
  localparam logic [BUS_AW-1:0] REG_INSN2 = 8'h08;
  localparam logic [BUS_AW-1:0] REG_STAT  = 8'h0c;
  localparam logic [BUS_AW-1:0] REG_MADDR = 8'h10;
  localparam logic [BUS_AW-1:0] REG_MDATA = 8'h14;

  // =====================================================================
  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_SKIP_BIT  = 1;
  localparam int unsigned STAT_CYC_LSB   = 4;
  localparam int unsigned STAT_W_LSB     = 8;
  localparam int unsigned STAT_FLAG_LSB  = 16;
  localparam int unsigned FLAG_N_BIT     = 4;
  localparam int unsigned FLAG_Z_BIT     = 2;

  // =====================================================================
  // data space locations of the core registers
  localparam logic [11:0] ADR_ACC      = 12'hff0;
  localparam logic [11:0] ADR_BANK     = 12'hff1;
  localparam logic [11:0] ADR_STATUS   = 12'hff2;
  localparam logic [11:0] ADR_PROD_LO  = 12'hff3;
  localparam logic [11:0] ADR_PROD_HI  = 12'hff4;
  localparam logic [11:0] ADR_PTR_BASE = 12'hff5;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BK = 4'hf;

  // =====================================================================
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_INSN = 16'h0000;
  localparam logic [11:0] RST_PTR  = 12'h000;

  // =====================================================================
  // opcode fields
  localparam logic [7:0] OP_OR_LIT    = 8'h09;
  localparam logic [7:0] OP_SET_BANK  = 8'h01;
  localparam logic [7:0] OP_LOAD_LIT  = 8'h0e;
  localparam logic [7:0] OP_MUL_LIT   = 8'h0d;
  localparam logic [9:0] OP_LOAD_PTR  = 10'b1110111000;
  localparam logic [5:0] OP_OR_FILE   = 6'b000100;
  localparam logic [5:0] OP_COPY_F    = 6'b010100;
  localparam logic [5:0] OP_INC_SKIP  = 6'b010010;
  localparam logic [6:0] OP_STORE_W   = 7'b0110111;
  localparam logic [3:0] OP_COPY_FF   = 4'hc;
  localparam logic [5:0] OP_LONG_HI   = 6'b111011;

  // =====================================================================
  // phases of one instruction cycle
  localparam logic [1:0] PH_READ  = 2'd1;
  localparam logic [1:0] PH_PROC  = 2'd2;
  localparam logic [1:0] PH_WRITE = 2'd3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC1 = 2'b01,
    ST_EXEC2 = 2'b11,
    ST_SKIP  = 2'b10
  } cmo_state_t;
endpackage
`default_nettype wire

// ===== hdl/cmo_axil_slave.sv
`default_nettype none
module cmo_axil_slave
  import cmo_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [BUS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [BUS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   reg_we,
  output logic [BUS_AW-1:0]      reg_waddr,
  output logic [31:0]            reg_wdata,
  output logic [3:0]             reg_wstrb,
  input  wire logic              reg_werr,
  output logic [BUS_AW-1:0]      reg_raddr,
  input  wire logic [31:0]       reg_rdata,
  input  wire logic              reg_rerr
);
  // =====================================================================
  // write channels: address and data are caught independently
  logic              aw_full_q;
  logic              w_full_q;
  logic [BUS_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign reg_we        = aw_full_q && w_full_q && !s_axi_bvalid;
  assign reg_waddr     = awaddr_q;
  assign reg_wdata     = wdata_q;
  assign reg_wstrb     = wstrb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (reg_we) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (reg_we) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (reg_we) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_werr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =====================================================================
  // read channel: reads have no side effects, so data is sampled at once
  assign s_axi_arready = !s_axi_rvalid;
  assign reg_raddr     = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_rdata;
      s_axi_rresp  <= reg_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cmo_axil_slave
`default_nettype wire

// ===== hdl/cmo_core.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
// Notes on behaviour
// RULE1 - or with literal or file register updates the negative and zero flags, d=0 to working register, d=1 to the file.
// RULE2 - access-select 0 forces the access bank, 1 takes the bank from the bank select register.
// RULE3 - load pointer puts a 12-bit literal into pointer 0..2, high part in cycle one, low byte in cycle two.
// RULE4 - copy file register moves the file to the working register (d=0) or back to itself (d=1) and sets N and Z.
// RULE5 - file-to-file copy uses full 12-bit source and destination addresses, ignoring the bank selector.
// RULE6 - file-to-file copy reaches the working register as an ordinary data-space location.
// RULE7 - software never names the program counter low byte or a stack top byte as file-to-file destination.
// RULE8 - file-to-file copy reads the source in phase two of cycle one and writes in phase four of cycle two.
// RULE9 - set bank loads its 8-bit literal into the bank select register in one cycle, flags untouched.
// RULE10 - store accumulator writes the working register into the banked file register, flags untouched.
// RULE11 - literal multiply puts the 16-bit unsigned product into the product high and low bytes in one cycle.
// RULE12 - literal multiply leaves the working register and all flags unchanged, zero product is not flagged.
// RULE13 - a nonzero increment-skip result turns the next instruction into a no-op of one or two cycles.
// RULE14 - load literal puts its 8-bit literal into the working register in one cycle, flags untouched.
module cmo_core
  import cmo_pkg::*;
#(
  parameter int unsigned QDIV = 1
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [BUS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [BUS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  if (QDIV < 1 || QDIV > 255) begin : g_bad_qdiv
    $error("QDIV must lie between 1 and 255");
  end

  localparam int unsigned DEPTH = 2 ** DATA_AW;

  // =====================================================================
  // declarations
  cmo_state_t        state_q;
  logic [1:0]        q_q;
  logic [7:0]        div_q;
  logic              phase_en;
  logic              busy;
  logic              end_cyc;
  logic [15:0]       insn1_q;
  logic [15:0]       insn2_q;
  logic [11:0]       maddr_q;
  logic [7:0]        acc_q;
  logic [7:0]        bank_q;
  logic [7:0]        status_q;
  logic [7:0]        prod_lo_q;
  logic [7:0]        prod_hi_q;
  logic [11:0]       ptr_q [PTR_COUNT];
  logic [7:0]        mem_q [DEPTH];
  logic [7:0]        opnd_q;
  logic [7:0]        res_q;
  logic              skip_q;
  logic              skip_left_q;
  logic [3:0]        cyc_q;
  logic              reg_we;
  logic [BUS_AW-1:0] reg_waddr;
  logic [31:0]       reg_wdata;
  logic [3:0]        reg_wstrb;
  logic              reg_werr;
  logic [BUS_AW-1:0] reg_raddr;
  logic [31:0]       reg_rdata;
  logic              reg_rerr;
  logic              bus_ok;
  logic              start;
  logic              is_orl, is_orf, is_cpf, is_inf, is_stw;
  logic              is_setb, is_ldl, is_mul, is_ldp, is_cpff;
  logic              two_word;
  logic [1:0]        ptr_sel;
  logic [7:0]        lit;
  logic              dest_f;
  logic [11:0]       eff_addr;
  logic              dw_we;
  logic [11:0]       dw_addr;
  logic [7:0]        dw_data;
  logic              flag_we;
  logic              prod_we;
  logic              ptr_hi_we;
  logic              ptr_lo_we;
  logic [15:0]       product;

  // =====================================================================
  // register bus
  cmo_axil_slave cmo_axil_slave_i (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_we        (reg_we),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_werr      (reg_werr),
    .reg_raddr     (reg_raddr),
    .reg_rdata     (reg_rdata),
    .reg_rerr      (reg_rerr)
  );

  // writes would race the sequencer, so they are refused while it runs
  assign bus_ok   = reg_waddr == REG_CTRL || reg_waddr == REG_INSN1 ||
                    reg_waddr == REG_INSN2 || reg_waddr == REG_MADDR ||
                    reg_waddr == REG_MDATA;
  assign reg_werr = !bus_ok || busy;
  assign start    = reg_we && !busy && reg_waddr == REG_CTRL &&
                    reg_wstrb[0] && reg_wdata[CTRL_START_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn1_q <= RST_INSN;
      insn2_q <= RST_INSN;
      maddr_q <= '0;
    end else if (reg_we && !busy) begin
      if (reg_waddr == REG_INSN1 && reg_wstrb[0]) insn1_q[7:0]  <= reg_wdata[7:0];
      if (reg_waddr == REG_INSN1 && reg_wstrb[1]) insn1_q[15:8] <= reg_wdata[15:8];
      if (reg_waddr == REG_INSN2 && reg_wstrb[0]) insn2_q[7:0]  <= reg_wdata[7:0];
      if (reg_waddr == REG_INSN2 && reg_wstrb[1]) insn2_q[15:8] <= reg_wdata[15:8];
      if (reg_waddr == REG_MADDR && reg_wstrb[0]) maddr_q[7:0]  <= reg_wdata[7:0];
      if (reg_waddr == REG_MADDR && reg_wstrb[1]) maddr_q[11:8] <= reg_wdata[11:8];
    end
  end

  // data space view shared by the sequencer and the memory window
  function automatic logic [7:0] ds_read(input logic [11:0] a);
    logic [7:0] v;
    v = mem_q[a];
    case (a)
      ADR_ACC:     v = acc_q;
      ADR_BANK:    v = bank_q;
      ADR_STATUS:  v = status_q;
      ADR_PROD_LO: v = prod_lo_q;
      ADR_PROD_HI: v = prod_hi_q;
      default:     ;
    endcase
    for (int i = 0; i < PTR_COUNT; i++) begin
      if (a == ADR_PTR_BASE + 12'(2 * i)) v = ptr_q[i][7:0];
      if (a == ADR_PTR_BASE + 12'(2 * i + 1)) v = {4'h0, ptr_q[i][11:8]};
    end
    return v;
  endfunction

  always_comb begin
    reg_rdata = '0;
    reg_rerr  = 1'b0;
    case (reg_raddr)
      REG_CTRL:  reg_rdata[CTRL_START_BIT] = busy;
      REG_INSN1: reg_rdata[15:0] = insn1_q;
      REG_INSN2: reg_rdata[15:0] = insn2_q;
      REG_MADDR: reg_rdata[11:0] = maddr_q;
      REG_MDATA: reg_rdata[7:0] = ds_read(maddr_q);
      REG_STAT: begin
        reg_rdata[STAT_BUSY_BIT]                   = busy;
        reg_rdata[STAT_SKIP_BIT]                   = skip_q;
        reg_rdata[STAT_CYC_LSB +: 4]               = cyc_q;
        reg_rdata[STAT_W_LSB +: 8]                 = acc_q;
        reg_rdata[STAT_FLAG_LSB +: 8]              = status_q;
      end
      default:   reg_rerr = 1'b1;
    endcase
  end

  // =====================================================================
  // decode
  assign lit      = insn1_q[7:0];
  assign dest_f   = insn1_q[9];
  assign ptr_sel  = insn1_q[5:4];
  assign is_orl   = insn1_q[15:8] == OP_OR_LIT;
  assign is_orf   = insn1_q[15:10] == OP_OR_FILE;
  assign is_cpf   = insn1_q[15:10] == OP_COPY_F;
  assign is_inf   = insn1_q[15:10] == OP_INC_SKIP;
  assign is_stw   = insn1_q[15:9] == OP_STORE_W;
  assign is_setb  = insn1_q[15:8] == OP_SET_BANK;
  assign is_ldl   = insn1_q[15:8] == OP_LOAD_LIT;
  assign is_mul   = insn1_q[15:8] == OP_MUL_LIT;
  assign is_ldp   = insn1_q[15:6] == OP_LOAD_PTR && ptr_sel < 2'(PTR_COUNT);
  assign is_cpff  = insn1_q[15:12] == OP_COPY_FF;
  assign two_word = is_cpff || insn1_q[15:10] == OP_LONG_HI;
  // bank register holds 8 bits; only its low nibble reaches the 12-bit space
  assign eff_addr = insn1_q[8] ? {bank_q[3:0], lit} :                       // [RULE2]
                    (lit < ACCESS_SPLIT ? {4'h0, lit} : {ACCESS_HI_BK, lit}); // [RULE2]
  assign product  = 16'(acc_q) * 16'(lit);                                  // [RULE11]

  // =====================================================================
  // phase sequencer: one phase per QDIV clocks
  assign busy     = state_q != ST_IDLE;
  assign phase_en = busy && div_q == 8'(QDIV - 1);
  assign end_cyc  = phase_en && q_q == PH_WRITE;

  always_ff @(posedge aclk) begin
    if (!aresetn || start || phase_en) begin
      div_q <= '0;
    end else if (busy) begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      q_q <= 2'd0;
    end else if (phase_en) begin
      q_q <= q_q + 2'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      skip_left_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && skip_q) begin
            state_q     <= ST_SKIP;                       // [RULE13]
            skip_left_q <= two_word;                      // [RULE13]
          end else if (start) begin
            state_q <= ST_EXEC1;
          end
        end
        ST_EXEC1: begin
          if (end_cyc) state_q <= (is_ldp || is_cpff) ? ST_EXEC2 : ST_IDLE; // [RULE3] [RULE8]
        end
        ST_EXEC2: begin
          if (end_cyc) state_q <= ST_IDLE;
        end
        ST_SKIP: begin
          if (end_cyc && skip_left_q) skip_left_q <= 1'b0;
          else if (end_cyc) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // skip is only ever set inside a run and only cleared by a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_q <= 1'b0;
    end else if (state_q == ST_EXEC1 && end_cyc && is_inf && res_q != 8'h00) begin
      skip_q <= 1'b1;                                     // [RULE13]
    end else if (start) begin
      skip_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      cyc_q <= 4'h0;
    end else if (end_cyc) begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  // =====================================================================
  // operand read and processing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd_q <= RST_BYTE;
    end else if (state_q == ST_EXEC1 && phase_en && q_q == PH_READ) begin
      opnd_q <= ds_read(is_cpff ? insn1_q[11:0] : eff_addr); // [RULE5] [RULE8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= RST_BYTE;
    end else if (state_q == ST_EXEC1 && phase_en && q_q == PH_PROC) begin
      if (is_orl) res_q <= acc_q | lit;                   // [RULE1]
      else if (is_orf) res_q <= acc_q | opnd_q;           // [RULE1]
      else if (is_cpf) res_q <= opnd_q;                   // [RULE4]
      else if (is_inf) res_q <= opnd_q + 8'h01;           // [RULE13]
      else if (is_stw) res_q <= acc_q;                    // [RULE10]
      else res_q <= lit;                                  // [RULE9] [RULE14]
    end
  end

  // =====================================================================
  // write-back in phase four
  always_comb begin
    dw_we     = 1'b0;
    dw_addr   = maddr_q;
    dw_data   = reg_wdata[7:0];
    flag_we   = 1'b0;
    prod_we   = 1'b0;
    ptr_hi_we = 1'b0;
    ptr_lo_we = 1'b0;
    if (!busy) begin
      dw_we = reg_we && reg_waddr == REG_MDATA && reg_wstrb[0];
    end else if (end_cyc && state_q == ST_EXEC1) begin
      dw_data = res_q;
      if (is_orl || is_ldl) begin
        dw_we   = 1'b1;                                   // [RULE1] [RULE14]
        dw_addr = ADR_ACC;
      end else if (is_orf || is_cpf || is_inf) begin
        dw_we   = 1'b1;
        dw_addr = dest_f ? eff_addr : ADR_ACC;            // [RULE1] [RULE4]
      end else if (is_stw) begin
        dw_we   = 1'b1;                                   // [RULE10]
        dw_addr = eff_addr;
      end else if (is_setb) begin
        dw_we   = 1'b1;                                   // [RULE9]
        dw_addr = ADR_BANK;
      end
      flag_we   = is_orl || is_orf || is_cpf;             // [RULE1] [RULE4]
      prod_we   = is_mul;                                 // [RULE11] [RULE12]
      ptr_hi_we = is_ldp;                                 // [RULE3]
    end else if (end_cyc && state_q == ST_EXEC2) begin
      ptr_lo_we = is_ldp;                                 // [RULE3]
      // no dummy read; destinations are not screened, software must avoid them
      dw_we   = is_cpff;                                  // [RULE8]
      dw_addr = insn2_q[11:0];                            // [RULE5] [RULE6]
      dw_data = opnd_q;
    end
  end

  // memory also shadows core register addresses; reads pick the register
  always_ff @(posedge aclk) begin
    if (dw_we) mem_q[dw_addr] <= dw_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) acc_q <= RST_BYTE;
    else if (dw_we && dw_addr == ADR_ACC) acc_q <= dw_data; // [RULE6]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) bank_q <= RST_BYTE;
    else if (dw_we && dw_addr == ADR_BANK) bank_q <= dw_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= RST_BYTE;
    end else if (dw_we && dw_addr == ADR_STATUS) begin
      status_q <= dw_data;
    end else if (flag_we) begin
      status_q[FLAG_N_BIT] <= res_q[7];                   // [RULE1] [RULE4]
      status_q[FLAG_Z_BIT] <= res_q == 8'h00;             // [RULE1] [RULE4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prod_lo_q <= RST_BYTE;
      prod_hi_q <= RST_BYTE;
    end else if (prod_we) begin
      prod_lo_q <= product[7:0];                          // [RULE11]
      prod_hi_q <= product[15:8];                         // [RULE11]
    end else if (dw_we) begin
      if (dw_addr == ADR_PROD_LO) prod_lo_q <= dw_data;
      if (dw_addr == ADR_PROD_HI) prod_hi_q <= dw_data;
    end
  end

  for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
    localparam logic [11:0] ADR_LO = ADR_PTR_BASE + 12'(2 * i);
    localparam logic [11:0] ADR_HI = ADR_PTR_BASE + 12'(2 * i + 1);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ptr_q[i] <= RST_PTR;
      end else if (ptr_hi_we && ptr_sel == 2'(i)) begin
        ptr_q[i][11:8] <= insn1_q[3:0];                   // [RULE3]
      end else if (ptr_lo_we && ptr_sel == 2'(i)) begin
        ptr_q[i][7:0] <= insn2_q[7:0];                    // [RULE3]
      end else if (dw_we && dw_addr == ADR_LO) begin
        ptr_q[i][7:0] <= dw_data;
      end else if (dw_we && dw_addr == ADR_HI) begin
        ptr_q[i][11:8] <= dw_data[3:0];
      end
    end
  end
endmodule // cmo_core
`default_nettype wire

// ===== verification/cmo_core_assertions.sv
`default_nettype none
module cmo_core_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write reply");
  AST_B_BLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("b");
  AST_B_END: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b end");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r lat");
  AST_R_END: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r end");
  AST_R_BLK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar while busy");
  AST_R_IDL: assert property (!s_axi_rvalid |-> s_axi_arready) else $error("ar stuck");
  AST_R_SPU: assert property (!s_axi_arvalid && !s_axi_rvalid |=> !s_axi_rvalid) else $error("r");
endmodule // cmo_core_assertions
bind cmo_core cmo_core_assertions cmo_core_assertions_i (.*);
`default_nettype wire

// ===== verification/cmo_core_tb.sv
`default_nettype none
module cmo_core_tb import cmo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rb;
  int          n_errors = 0, check_count = 0;
  always #12.5 aclk = ~aclk;
  cmo_core cmo_core_i (.*);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  // ready is sampled mid-cycle so the release lands just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rb = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        ck("bresp", 32'(e), 32'(rb));
        return;
      end
    end
    ck("write timeout", 32'h0, 32'h1);
    end_sim;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rb = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) return;
    end
    ck("read timeout", 32'h0, 32'h1);
    end_sim;
  endtask
  task automatic run(input logic [15:0] i1, i2, input logic [3:0] cyc);
    wr(REG_INSN1, {16'h0, i1}, RESP_OKAY);
    wr(REG_INSN2, {16'h0, i2}, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    for (int n = 0; n < 40; n++) begin
      rd(REG_STAT);
      if (d[STAT_BUSY_BIT] === 1'b0) begin
        ck("cycles", 32'(cyc), 32'(d[7:4]));
        return;
      end
    end
    ck("busy timeout", 32'h0, 32'h1);
    end_sim;
  endtask
  task automatic peek(input logic [11:0] a, input logic [7:0] e);
    wr(REG_MADDR, {20'h0, a}, RESP_OKAY);
    rd(REG_MDATA);
    ck("data", {24'h0, e}, d);
  endtask
  task automatic t_alu;
    run(16'h0e9a, 16'h0, 1);
    ck("w", 32'h9a, 32'(d[15:8]));
    run(16'h0935, 16'h0, 1);
    ck("flags w", 32'h10bf, 32'(d[23:8]));
    run(16'h0dc4, 16'h0, 1);
    ck("flags w", 32'h10bf, 32'(d[23:8]));
    peek(ADR_PROD_HI, 8'h92);
    peek(ADR_PROD_LO, 8'h3c);
    $display("t_alu done");
  endtask
  task automatic t_mem;
    run(16'h0105, 16'h0, 1);
    peek(ADR_BANK, 8'h05);
    run(16'h6f10, 16'h0, 1);
    peek(12'h510, 8'hbf);
    run(16'h6e20, 16'h0, 1);
    peek(12'h020, 8'hbf);
    run(16'h0e00, 16'h0, 1);
    run(16'hc510, 16'hfff0, 2);
    ck("flags w", 32'h10bf, 32'(d[23:8]));
    run(16'hcff0, 16'hf7ff, 2);
    peek(12'h7ff, 8'hbf);
    run(16'hee23, 16'hf0ab, 2);
    peek(12'hff9, 8'hab);
    peek(12'hffa, 8'h03);
    $display("t_mem done");
  endtask
  task automatic t_skip;
    wr(REG_MADDR, 32'h020, RESP_OKAY);
    wr(REG_MDATA, 32'h0, RESP_OKAY);
    run(16'h5020, 16'h0, 1);
    ck("flags w", 32'h0400, 32'(d[23:8]));
    run(16'h0e05, 16'h0, 1);
    run(16'h1220, 16'h0, 1);
    ck("flags w", 32'h0005, 32'(d[23:8]));
    peek(12'h020, 8'h05);
    run(16'h4a20, 16'h0, 1);
    ck("skip", 32'h1, 32'(d[STAT_SKIP_BIT]));
    run(16'h0e77, 16'h0, 1);
    ck("w", 32'h05, 32'(d[15:8]));
    run(16'h4a20, 16'h0, 1);
    run(16'hc510, 16'hf020, 2);
    peek(12'h020, 8'h07);
    $display("t_skip done");
  endtask
  task automatic t_bus;
    wr(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_STAT, 32'h0, RESP_SLVERR);
    rd(8'h40);
    ck("rdata", 32'h0, d);
    ck("rresp", 32'(RESP_SLVERR), 32'(rb));
    $display("t_bus done");
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_alu();
    t_mem();
    t_skip();
    t_bus();
    end_sim();
  end
endmodule // cmo_core_tb
`default_nettype wire
